// [pt32_pkg.sv]
// Package of constants and types for the paired 32-bit timer
`default_nettype none

package pt32_pkg;

    // ************************************************************
    // Register offsets (byte addresses, one 32-bit word each)
    // ************************************************************
    localparam logic [7:0] OFS_EVEN_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ODD_CTRL    = 8'h04;
    localparam logic [7:0] OFS_EVEN_COUNT  = 8'h08;
    localparam logic [7:0] OFS_ODD_COUNT   = 8'h0C;
    localparam logic [7:0] OFS_EVEN_PERIOD = 8'h10;
    localparam logic [7:0] OFS_ODD_PERIOD  = 8'h14;
    localparam logic [7:0] OFS_IRQ_CFG     = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAG    = 8'h1C;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int unsigned CTL_ON_BIT   = 15;
    localparam int unsigned CTL_GATE_BIT = 6;
    localparam int unsigned CTL_PS_LSB   = 4;
    localparam int unsigned CTL_JOIN_BIT = 3;
    localparam int unsigned CTL_CSS_BIT  = 1;

    // ************************************************************
    // Interrupt configuration and flag fields
    // ************************************************************
    localparam int unsigned IRQ_EVEN_IE_BIT  = 0;
    localparam int unsigned IRQ_EVEN_IP_LSB  = 4;
    localparam int unsigned IRQ_ODD_IE_BIT   = 8;
    localparam int unsigned IRQ_ODD_IP_LSB   = 12;
    localparam int unsigned FLAG_EVEN_BIT    = 0;
    localparam int unsigned FLAG_ODD_BIT     = 1;

    // ************************************************************
    // Reset values and prescaler terminal counts
    // ************************************************************
    localparam logic [15:0] PERIOD_RST  = 16'hFFFF;
    localparam logic [7:0]  PS_LAST_1   = 8'h00;
    localparam logic [7:0]  PS_LAST_8   = 8'h07;
    localparam logic [7:0]  PS_LAST_64  = 8'h3F;
    localparam logic [7:0]  PS_LAST_256 = 8'hFF;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic        timer_on;
        logic        gate_enable;
        logic [1:0]  prescale_select;
        logic        pair_join_bit;
        logic        clock_source_select;
        logic [15:0] count;
        logic [15:0] period;
        logic [7:0]  psc;
        logic        ext_prev;
        logic        flag;
        logic        irq_enable;
        logic [2:0]  irq_priority;
    } pt32_tmr_t;

    typedef struct packed {
        logic dma;
        logic adc1;
        logic adc2;
    } pt32_trig_t;

    typedef struct packed {
        pt32_tmr_t   ev;
        pt32_tmr_t   od;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq_even;
        logic        irq_odd;
        pt32_trig_t  trig;
        logic [31:0] timebase;
    } pt32_state_t;

endpackage

`default_nettype wire

// [pt32_timer_pair.sv]
// Timer pair: two 16-bit timers or one 32-bit timer/counter behind an APB slave
//
// Contract
// - Pair runs as one 32-bit or two 16-bit
// - Two 16-bit, 32-bit timer, 32-bit counter arrangements
// - Each 16-bit timer: synchronous timer or counter
// - Joined mode ignores odd timer control bits
// - Joined: even clock/gate, odd interrupt flag
// - Odd count upper word, even lower word
// - Odd period upper word, even lower word
// - Interrupt on full 32-bit period match
// - Two-bit prescale select in control register
// - Clock-source select and gate-enable bits
// - Per-timer irq enable, three-bit priority
// - DMA only pair zero; ADC triggers pairs 0/1
// - Only pair zero provides capture/compare time base
// - Timers keep running in Idle and Sleep
//
// Design decisions made here: the APB slave port and the placing of the registers.
`default_nettype none

module pt32_timer_pair #(
    parameter int unsigned PAIR_INDEX = 0
) (
    input  wire logic               sys_clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [31:0]             prdata,
    input  wire logic               ext_clk_even,
    input  wire logic               ext_clk_odd,
    input  wire logic               gate_even,
    input  wire logic               gate_odd,
    output logic                    irq_even,
    output logic                    irq_odd,
    output logic [2:0]              irq_prio_even,
    output logic [2:0]              irq_prio_odd,
    output pt32_pkg::pt32_trig_t    trig,
    output logic [31:0]             cc_timebase
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] ps_last(input logic [1:0] sel);
        unique case (sel)
            2'h0: ps_last = pt32_pkg::PS_LAST_1;
            2'h1: ps_last = pt32_pkg::PS_LAST_8;
            2'h2: ps_last = pt32_pkg::PS_LAST_64;
            2'h3: ps_last = pt32_pkg::PS_LAST_256;
        endcase
    endfunction

    // Count source before prescaling: external edge, gated or free system clock
    function automatic logic src_event(input pt32_pkg::pt32_tmr_t t, input logic ext, input logic gate);
        if (t.clock_source_select)
        begin
            src_event = ext & ~t.ext_prev;
        end
        else
        begin
            src_event = t.gate_enable ? gate : 1'b1;
        end
    endfunction

    function automatic logic [31:0] ctrl_word(input pt32_pkg::pt32_tmr_t t, input logic even);
        ctrl_word = '0;
        ctrl_word[pt32_pkg::CTL_ON_BIT] = t.timer_on;
        ctrl_word[pt32_pkg::CTL_GATE_BIT] = t.gate_enable;
        ctrl_word[pt32_pkg::CTL_PS_LSB +: 2] = t.prescale_select;
        ctrl_word[pt32_pkg::CTL_JOIN_BIT] = even & t.pair_join_bit;
        ctrl_word[pt32_pkg::CTL_CSS_BIT] = t.clock_source_select;
    endfunction

    function automatic pt32_pkg::pt32_tmr_t ctrl_load(input pt32_pkg::pt32_tmr_t t,
                                                      input logic [31:0] d, input logic even);
        ctrl_load = t;
        ctrl_load.timer_on = d[pt32_pkg::CTL_ON_BIT];
        ctrl_load.gate_enable = d[pt32_pkg::CTL_GATE_BIT];
        ctrl_load.prescale_select = d[pt32_pkg::CTL_PS_LSB +: 2];
        ctrl_load.pair_join_bit = even & d[pt32_pkg::CTL_JOIN_BIT];
        ctrl_load.clock_source_select = d[pt32_pkg::CTL_CSS_BIT];
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    pt32_pkg::pt32_state_t s_reg;
    pt32_pkg::pt32_state_t s_next;
    logic                  joined;
    logic                  tick_ev;
    logic                  tick_od;
    logic                  match_ev;
    logic                  match_od;
    logic                  match_32;
    logic                  wr_en;
    logic [31:0]           cnt32;
    logic [31:0]           per32;
    logic [31:0]           rd_word;
    logic                  mapped;
    logic [1:0]            flag_clr;

    assign joined = s_reg.ev.pair_join_bit;
    assign cnt32  = {s_reg.od.count, s_reg.ev.count};
    assign per32  = {s_reg.od.period, s_reg.ev.period};
    assign wr_en  = psel & penable & pwrite & s_reg.pready;

    always_comb
    begin
        s_next = s_reg;
        s_next.trig = '0;
        tick_ev = 1'b0;
        tick_od = 1'b0;
        match_ev = 1'b0;
        match_od = 1'b0;
        match_32 = 1'b0;
        flag_clr = 2'h0;
        mapped = 1'b1;
        rd_word = '0;

        // ********************************************************
        // APB slave: zero wait states, read data captured in setup
        // ********************************************************
        unique case (paddr)
            pt32_pkg::OFS_EVEN_CTRL:   rd_word = ctrl_word(s_reg.ev, 1'b1);
            pt32_pkg::OFS_ODD_CTRL:    rd_word = ctrl_word(s_reg.od, 1'b0);
            pt32_pkg::OFS_EVEN_COUNT:  rd_word = {16'h0000, s_reg.ev.count};
            pt32_pkg::OFS_ODD_COUNT:   rd_word = {16'h0000, s_reg.od.count};
            pt32_pkg::OFS_EVEN_PERIOD: rd_word = {16'h0000, s_reg.ev.period};
            pt32_pkg::OFS_ODD_PERIOD:  rd_word = {16'h0000, s_reg.od.period};
            pt32_pkg::OFS_IRQ_CFG:
            begin
                rd_word[pt32_pkg::IRQ_EVEN_IE_BIT] = s_reg.ev.irq_enable;
                rd_word[pt32_pkg::IRQ_EVEN_IP_LSB +: 3] = s_reg.ev.irq_priority;
                rd_word[pt32_pkg::IRQ_ODD_IE_BIT] = s_reg.od.irq_enable;
                rd_word[pt32_pkg::IRQ_ODD_IP_LSB +: 3] = s_reg.od.irq_priority;
            end
            pt32_pkg::OFS_IRQ_FLAG:
            begin
                rd_word[pt32_pkg::FLAG_EVEN_BIT] = s_reg.ev.flag;
                rd_word[pt32_pkg::FLAG_ODD_BIT] = s_reg.od.flag;
            end
            default:                   mapped = 1'b0;
        endcase

        if (psel & ~penable)
        begin
            s_next.pready = 1'b1;
            s_next.pslverr = ~mapped;
            s_next.prdata = mapped ? rd_word : 32'h0000_0000;
        end
        else
        begin
            s_next.pready = 1'b0;
            s_next.pslverr = 1'b0;
        end

        if (wr_en)
        begin
            unique case (paddr)
                pt32_pkg::OFS_EVEN_CTRL:   s_next.ev = ctrl_load(s_reg.ev, pwdata, 1'b1);
                pt32_pkg::OFS_ODD_CTRL:    s_next.od = ctrl_load(s_reg.od, pwdata, 1'b0);
                pt32_pkg::OFS_EVEN_PERIOD: s_next.ev.period = pwdata[15:0];
                pt32_pkg::OFS_ODD_PERIOD:  s_next.od.period = pwdata[15:0];
                pt32_pkg::OFS_IRQ_CFG:
                begin
                    s_next.ev.irq_enable = pwdata[pt32_pkg::IRQ_EVEN_IE_BIT];
                    s_next.ev.irq_priority = pwdata[pt32_pkg::IRQ_EVEN_IP_LSB +: 3];
                    s_next.od.irq_enable = pwdata[pt32_pkg::IRQ_ODD_IE_BIT];
                    s_next.od.irq_priority = pwdata[pt32_pkg::IRQ_ODD_IP_LSB +: 3];
                end
                pt32_pkg::OFS_IRQ_FLAG:
                begin
                    flag_clr[0] = pwdata[pt32_pkg::FLAG_EVEN_BIT];
                    flag_clr[1] = pwdata[pt32_pkg::FLAG_ODD_BIT];
                end
                default:                   mapped = mapped;
            endcase
        end

        // ********************************************************
        // Prescalers; power-saving modes do not gate the count
        // ********************************************************
        s_next.ev.ext_prev = ext_clk_even;
        s_next.od.ext_prev = ext_clk_odd;
        if (s_reg.ev.timer_on)
        begin
            if (src_event(s_reg.ev, ext_clk_even, gate_even))
            begin
                if (s_reg.ev.psc == ps_last(s_reg.ev.prescale_select))
                begin
                    s_next.ev.psc = 8'h00;
                    tick_ev = 1'b1;
                end
                else
                begin
                    s_next.ev.psc = s_reg.ev.psc + 8'h01;
                end
            end
        end
        else
        begin
            s_next.ev.psc = 8'h00;
        end
        // Odd prescaler sits idle while joined, so its control bits have no effect
        if (s_reg.od.timer_on && !joined)
        begin
            if (src_event(s_reg.od, ext_clk_odd, gate_odd))
            begin
                if (s_reg.od.psc == ps_last(s_reg.od.prescale_select))
                begin
                    s_next.od.psc = 8'h00;
                    tick_od = 1'b1;
                end
                else
                begin
                    s_next.od.psc = s_reg.od.psc + 8'h01;
                end
            end
        end
        else
        begin
            s_next.od.psc = 8'h00;
        end

        // ********************************************************
        // Counters
        // ********************************************************
        s_next.ev.flag = s_reg.ev.flag & ~flag_clr[0];
        s_next.od.flag = s_reg.od.flag & ~flag_clr[1];
        if (joined)
        begin
            if (tick_ev)
            begin
                if (cnt32 == per32)
                begin
                    match_32 = 1'b1;
                    {s_next.od.count, s_next.ev.count} = 32'h0000_0000;
                    s_next.od.flag = 1'b1;
                end
                else
                begin
                    {s_next.od.count, s_next.ev.count} = cnt32 + 32'h0000_0001;
                end
            end
        end
        else
        begin
            if (tick_ev)
            begin
                match_ev = (s_reg.ev.count == s_reg.ev.period);
                s_next.ev.count = match_ev ? 16'h0000 : s_reg.ev.count + 16'h0001;
                s_next.ev.flag = s_next.ev.flag | match_ev;
            end
            if (tick_od)
            begin
                match_od = (s_reg.od.count == s_reg.od.period);
                s_next.od.count = match_od ? 16'h0000 : s_reg.od.count + 16'h0001;
                s_next.od.flag = s_next.od.flag | match_od;
            end
        end
        // A software write to a count word wins over the increment
        if (wr_en && paddr == pt32_pkg::OFS_EVEN_COUNT)
        begin
            s_next.ev.count = pwdata[15:0];
        end
        if (wr_en && paddr == pt32_pkg::OFS_ODD_COUNT)
        begin
            s_next.od.count = pwdata[15:0];
        end

        // ********************************************************
        // Interrupts, triggers and time base
        // ********************************************************
        s_next.irq_even = s_next.ev.flag & s_next.ev.irq_enable & ~s_next.ev.pair_join_bit;
        s_next.irq_odd = s_next.od.flag & s_next.od.irq_enable;
        s_next.trig.dma = (PAIR_INDEX == 0) && (match_32 || match_ev);
        s_next.trig.adc1 = (PAIR_INDEX == 0) && (match_32 || match_ev);
        s_next.trig.adc2 = (PAIR_INDEX == 1) && (match_32 || match_ev);
        s_next.timebase = (PAIR_INDEX == 0) ? {s_next.od.count, s_next.ev.count} : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s_reg <= '0;
            s_reg.ev.period <= pt32_pkg::PERIOD_RST;
            s_reg.od.period <= pt32_pkg::PERIOD_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign pready        = s_reg.pready;
    assign pslverr       = s_reg.pslverr;
    assign prdata        = s_reg.prdata;
    assign irq_even      = s_reg.irq_even;
    assign irq_odd       = s_reg.irq_odd;
    assign irq_prio_even = s_reg.ev.irq_priority;
    assign irq_prio_odd  = s_reg.od.irq_priority;
    assign trig          = s_reg.trig;
    assign cc_timebase   = s_reg.timebase;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic no_cnt_wr;
    assign no_cnt_wr = !(wr_en && (paddr == pt32_pkg::OFS_EVEN_COUNT || paddr == pt32_pkg::OFS_ODD_COUNT));

    sequence seq_match32;
        joined && tick_ev && cnt32 == per32 && no_cnt_wr;
    endsequence

    sequence seq_wrapped;
        cnt32 == 32'h0000_0000 && s_reg.od.flag;
    endsequence

    chk_wrap_32bit: assert property (@(posedge sys_clk) disable iff (reset)
        seq_match32 |=> seq_wrapped)
        else $error("32-bit match did not wrap and flag");

    chk_carry_upper: assert property (@(posedge sys_clk) disable iff (reset)
        joined && tick_ev && cnt32 != per32 && s_reg.ev.count == 16'hFFFF && no_cnt_wr
        |=> s_reg.od.count == $past(s_reg.od.count) + 16'h0001 && s_reg.ev.count == 16'h0000)
        else $error("Lower word overflow did not carry into upper word");

    chk_odd_ignored: assert property (@(posedge sys_clk) disable iff (reset)
        joined |-> !tick_od && !match_od)
        else $error("Odd timer counted on its own while joined");

    chk_joined_irq: assert property (@(posedge sys_clk) disable iff (reset)
        seq_match32 ##1 s_reg.od.irq_enable |-> irq_odd)
        else $error("Joined match did not raise odd interrupt");

    chk_prescale_tick: assert property (@(posedge sys_clk) disable iff (reset)
        tick_ev |-> s_reg.ev.psc == ps_last(s_reg.ev.prescale_select))
        else $error("Even tick before prescaler terminal count");

    chk_gate_hold: assert property (@(posedge sys_clk) disable iff (reset)
        s_reg.ev.timer_on && s_reg.ev.gate_enable && !s_reg.ev.clock_source_select && !gate_even
        |-> !tick_ev ##1 (s_reg.ev.psc == $past(s_reg.ev.psc)))
        else $error("Gated timer advanced with gate low");

    chk_wrap_16bit: assert property (@(posedge sys_clk) disable iff (reset)
        !joined && tick_od && s_reg.od.count == s_reg.od.period && no_cnt_wr
        |=> s_reg.od.count == 16'h0000 && s_reg.od.flag)
        else $error("16-bit odd timer did not wrap and flag");

    chk_dma_pair0: assert property (@(posedge sys_clk) disable iff (reset)
        trig.dma |-> PAIR_INDEX == 0 && $past(match_32 || match_ev))
        else $error("DMA trigger without pair-zero period match");

    chk_timebase: assert property (@(posedge sys_clk) disable iff (reset)
        PAIR_INDEX != 0 |-> cc_timebase == 32'h0000_0000)
        else $error("Time base driven by a pair other than zero");

endmodule

`default_nettype wire

// [paired_timer_32bit_tb.sv]
// Self-checking testbench for the paired 32-bit timer
`default_nettype none

module paired_timer_32bit_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {logic [31:0] data; logic err; logic rd;} pt32_exp_t;

    logic                 sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic                 ext_clk_even, ext_clk_odd, gate_even, gate_odd, irq_even, irq_odd;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, cc_timebase;
    logic [2:0]           irq_prio_even, irq_prio_odd;
    pt32_pkg::pt32_trig_t trig;
    pt32_exp_t            exp_q[$];
    pt32_exp_t            mon_e;
    int                   err_total, total_checks, seed, n, k, per;
    int                   ratio[4] = '{1, 8, 64, 256};

    pt32_timer_pair #(.PAIR_INDEX(0)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ext_clk_even(ext_clk_even), .ext_clk_odd(ext_clk_odd), .gate_even(gate_even),
        .gate_odd(gate_odd), .irq_even(irq_even), .irq_odd(irq_odd), .irq_prio_even(irq_prio_even),
        .irq_prio_odd(irq_prio_odd), .trig(trig), .cc_timebase(cc_timebase)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Reporting
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp(logic [31:0] got, logic [31:0] want, string msg);
        total_checks++;
        if (got !== want)
        begin
            $display("[ERR] %0t %s got %h want %h", $time, msg, got, want);
            err_total++;
        end
    endtask

    // Monitor pairs each completed transfer with the oldest note
    always @(posedge sys_clk)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
        begin
            mon_e = exp_q.pop_front();
            total_checks++;
            if (pslverr !== mon_e.err || (mon_e.rd && prdata !== mon_e.data))
            begin
                $display("[ERR] %0t bus reply %h/%b want %h/%b", $time, prdata, pslverr, mon_e.data, mon_e.err);
                err_total++;
            end
        end
    end

    // ************************************************************
    // Bus and stimulus tasks
    // ************************************************************
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] want, logic err);
        int w;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back('{want, err, !wr});
        @(posedge sys_clk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge sys_clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (w >= 50)
        begin
            $display("[ERR] %0t bus hang", $time);
            err_total++;
            stop_test();
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] want);
        apb(1'b0, a, 32'h0, want, 1'b0);
    endtask

    function automatic logic [31:0] ctl(logic on, logic gate, logic [1:0] ps, logic jn, logic css);
        ctl = 32'h0;
        ctl[pt32_pkg::CTL_ON_BIT] = on;
        ctl[pt32_pkg::CTL_GATE_BIT] = gate;
        ctl[pt32_pkg::CTL_PS_LSB +: 2] = ps;
        ctl[pt32_pkg::CTL_JOIN_BIT] = jn;
        ctl[pt32_pkg::CTL_CSS_BIT] = css;
    endfunction

    task automatic wait_trig(output int c);
        c = 0;
        do
        begin
            @(posedge sys_clk);
            c++;
        end while (trig.adc1 !== 1'b1 && c < 2000);
        if (c >= 2000)
        begin
            $display("[ERR] %0t no period match", $time);
            err_total++;
            stop_test();
        end
        cmp({trig.dma, trig.adc2}, 2'b10, "trigger set");
    endtask

    // Slow pulses on the chosen external clocks, two cycles high and three low between pulses
    task automatic pulse(logic [1:0] m, int cnt);
        repeat (cnt)
        begin
            @(posedge sys_clk);
            {ext_clk_odd, ext_clk_even} <= m;
            repeat (2) @(posedge sys_clk);
            {ext_clk_odd, ext_clk_even} <= 2'b00;
            repeat (2) @(posedge sys_clk);
        end
    endtask

    // Lone timer t counts k events from gate or external source
    task automatic run_src(int t, logic gate, int cnt);
        logic [7:0] c;
        c = t ? pt32_pkg::OFS_ODD_CTRL : pt32_pkg::OFS_EVEN_CTRL;
        wr(c + 8'h10, 32'h0000FFFF);
        wr(c + 8'h08, 32'h0);
        wr(c, ctl(1'b1, gate, 2'b00, 1'b0, !gate));
        if (gate)
        begin
            @(posedge sys_clk);
            {gate_odd, gate_even} <= t ? 2'b10 : 2'b01;
            repeat (cnt) @(posedge sys_clk);
            {gate_odd, gate_even} <= 2'b00;
        end
        else
            pulse(t ? 2'b10 : 2'b01, cnt);
        wr(c, 32'h0);
        rd(c + 8'h08, cnt);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        seed = 49334;
        {reset, psel, penable, pwrite, ext_clk_even, ext_clk_odd, gate_even, gate_odd} = 8'h80;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        rd(pt32_pkg::OFS_EVEN_PERIOD, 32'h0000FFFF);
        rd(pt32_pkg::OFS_ODD_PERIOD, 32'h0000FFFF);
        rd(pt32_pkg::OFS_EVEN_CTRL, 32'h0);
        rd(pt32_pkg::OFS_ODD_COUNT, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        wr(pt32_pkg::OFS_EVEN_PERIOD, 32'h1);
        wr(pt32_pkg::OFS_IRQ_CFG, 32'h00000051);
        for (int ps = 0; ps < 4; ps++)
        begin
            wr(pt32_pkg::OFS_EVEN_CTRL, ctl(1'b0, 1'b0, ps[1:0], 1'b0, 1'b0));
            wr(pt32_pkg::OFS_EVEN_CTRL, ctl(1'b1, 1'b0, ps[1:0], 1'b0, 1'b0));
            wait_trig(n);
            wait_trig(n);
            cmp(n, 2 * ratio[ps], "prescaled interval");
        end
        // Back to 1:1 so the period interval stays short and equals period plus one
        wr(pt32_pkg::OFS_EVEN_CTRL, ctl(1'b1, 1'b0, 2'b00, 1'b0, 1'b0));
        per = 2 + ($unsigned($random(seed)) % 16);
        wr(pt32_pkg::OFS_EVEN_PERIOD, per);
        wait_trig(n);
        wait_trig(n);
        cmp(n, per + 1, "period interval");
        cmp({irq_even, irq_prio_even}, 4'hD, "even irq");
        wr(pt32_pkg::OFS_EVEN_CTRL, 32'h0);
        wr(pt32_pkg::OFS_IRQ_FLAG, 32'h1);
        rd(pt32_pkg::OFS_IRQ_FLAG, 32'h0);
        cmp(irq_even, 1'b0, "irq clear");
        for (int t = 0; t < 2; t++)
        begin
            k = 3 + ($unsigned($random(seed)) % 8);
            run_src(t, 1'b1, k);
            run_src(t, 1'b0, k);
        end
        // Lone odd timer runs exactly three ticks: 0, 1, 2 and wraps with its flag
        wr(pt32_pkg::OFS_ODD_COUNT, 32'h0);
        wr(pt32_pkg::OFS_ODD_PERIOD, 32'h2);
        wr(pt32_pkg::OFS_ODD_CTRL, ctl(1'b1, 1'b0, 2'b00, 1'b0, 1'b0));
        wr(pt32_pkg::OFS_ODD_CTRL, 32'h0);
        rd(pt32_pkg::OFS_ODD_COUNT, 32'h0);
        rd(pt32_pkg::OFS_IRQ_FLAG, 32'h2);
        wr(pt32_pkg::OFS_IRQ_FLAG, 32'h2);
        // Joined counter on even external clock; odd inputs wiggle but must not matter
        wr(pt32_pkg::OFS_EVEN_CTRL, ctl(1'b0, 1'b0, 2'b00, 1'b1, 1'b1));
        wr(pt32_pkg::OFS_ODD_CTRL, ctl(1'b1, 1'b1, 2'b11, 1'b0, 1'b0));
        wr(pt32_pkg::OFS_EVEN_COUNT, 32'h0000FFFE);
        wr(pt32_pkg::OFS_ODD_COUNT, 32'h0);
        wr(pt32_pkg::OFS_EVEN_PERIOD, 32'h2);
        wr(pt32_pkg::OFS_ODD_PERIOD, 32'h1);
        wr(pt32_pkg::OFS_IRQ_CFG, 32'h00006151);
        wr(pt32_pkg::OFS_EVEN_CTRL, ctl(1'b1, 1'b0, 2'b00, 1'b1, 1'b1));
        pulse(2'b11, 4);
        rd(pt32_pkg::OFS_ODD_COUNT, 32'h1);
        rd(pt32_pkg::OFS_EVEN_COUNT, 32'h2);
        cmp(cc_timebase, 32'h00010002, "time base");
        cmp(irq_odd, 1'b0, "early irq");
        pulse(2'b01, 1);
        repeat (3) @(posedge sys_clk);
        cmp({irq_odd, irq_even, irq_prio_odd}, 5'h16, "joined irq");
        cmp(cc_timebase, 32'h0, "wrap");
        rd(pt32_pkg::OFS_IRQ_FLAG, 32'h2);
        stop_test();
    end
endmodule

`default_nettype wire
